// [rtl/fbi_flash_bus_interface_unit.sv]
// Operation
// (R01) array is 128 Kbyte in eight independent 16-Kbyte blocks
// (R02) array fetches fill aligned 32-byte read pages of eight words
// (R03) two read pages are retained; hits in either skip the array fetch
// (R04) read missing both pages completes in two clocks and refills a page
// (R05) read hitting a retained page completes in one clock
// (R06) up to eight 64-byte pages programmed at once, same block offset
// (R07) each block can be protected against program and erase
// (R08) per block: supervisor-only or open, data-only or instruction and data
// (R09) stop bit set puts the module in low-power mode
// (R10) stop bit write accepted only while sequence bit is 0
// (R11) in stop mode config register stays reachable, array accesses ignored
// (R12) in stop mode other control registers end with bus error
// (R13) master should change the stop bit in a write of its own
// (R14) 16 clocks recovery after stop cleared; array reads stall till then
// (R15) disable bit set: array gives no response to accesses
// (R16) disable bit write accepted only while sequence bit is 0
// (R17) disable cleared: array accesses served at once, no recovery
// (R18) sequence bit write from 0 to 1 starts program or erase
// (R19) normal operation array writes end with bus error
// (R20) one page buffer for lower blocks, other for upper, both compared
// (R21) stop or disable write during high-voltage sequence keeps old value
// (R22) both read pages invalidated when leaving stop or disabled mode
`timescale 1ns/100ps
`default_nettype none
`include "fbi_regs.svh"

module fbi_flash_bus_interface_unit #(
  parameter int NUM_BLOCKS = `FBI_NUM_BLOCKS,
  parameter int ADDR_W = `FBI_ADDR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // array access from the bus master
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic req_super,
  input wire logic req_data,
  output logic req_ack,
  output logic req_err,
  output logic [31:0] req_rdata,
  // control register access
  input wire logic reg_valid,
  input wire logic reg_write,
  input wire logic [1:0] reg_target,
  input wire logic reg_wdata_stop,
  input wire logic reg_wdata_dis,
  input wire logic reg_wdata_seq,
  output logic reg_ack,
  output logic reg_err,
  // per-block attributes
  input wire logic [NUM_BLOCKS-1:0] blk_protect,
  input wire logic [NUM_BLOCKS-1:0] blk_super_only,
  input wire logic [NUM_BLOCKS-1:0] blk_data_only,
  // array page read port
  output logic arr_rd_en,
  output logic [11:0] arr_rd_page,
  input wire logic [255:0] arr_rd_data,
  // program page buffer load
  output logic pgm_wr,
  output logic [ADDR_W-1:0] pgm_addr,
  output logic [31:0] pgm_data,
  output logic [NUM_BLOCKS-1:0] pgm_blk_sel,
  // control state
  output logic flash_stop_bit,
  output logic array_disable_bit,
  output logic program_erase_sequence_bit,
  output logic pe_start,
  output logic low_power
);
  import fbi_pkg::*;

  fbi_state_t q, d;

  logic [2:0] blk;
  logic [11:0] tag;
  logic [2:0] wsel;
  logic [7:0] off;
  logic recovering;
  logic arr_live;
  logic attr_err;
  logic hit_lo, hit_hi, hit;
  logic [31:0] word_lo, word_hi;
  logic wr_ok;
  logic mcr_wr, hvc_wr;
  logic inval;

  // address fields
  assign blk = req_addr[`FBI_BLK_MSB:`FBI_BLK_LSB]; // [R01]
  assign tag = req_addr[ADDR_W-1:`FBI_PAGE_LSB]; // [R02]
  assign wsel = req_addr[`FBI_WORD_MSB:`FBI_WORD_LSB];
  assign off = req_addr[`FBI_PGM_OFF_MSB:`FBI_PGM_OFF_LSB];

  assign recovering = (q.rec_cnt_r != 5'h00);

  // stop ignores, disable gives no answer, recovery stalls; all three mean no ack
  assign arr_live = req_valid && !q.stop_r && !q.dis_r && !recovering; // [R11] [R15] [R14]

  // block restriction attributes
  assign attr_err = (blk_super_only[blk] && !req_super) ||
                    (blk_data_only[blk] && !req_data); // [R08]

  // lower blocks use the low page, upper blocks the high page
  assign hit = blk[2] ? hit_hi : hit_lo; // [R20] [R03]
  assign req_rdata = blk[2] ? word_hi : word_lo;

  // programming write: only inside a sequence, unprotected, common offset
  assign wr_ok = q.seq_r && !blk_protect[blk] &&
                 (!q.pgm_off_vld_r || (q.pgm_off_r == off)); // [R06] [R07] [R19]

  // one-clock answer on a hit, refill cycle first on a miss
  always_comb begin
    req_ack = 1'b0;
    req_err = 1'b0;
    arr_rd_en = 1'b0;
    if (arr_live) begin
      if (attr_err) begin
        req_ack = 1'b1;
        req_err = 1'b1;
      end else if (req_write) begin
        req_ack = 1'b1;
        req_err = !wr_ok; // [R19]
      end else if (hit) begin
        req_ack = 1'b1; // [R05]
      end else begin
        arr_rd_en = 1'b1; // [R04]
      end
    end
  end
  assign arr_rd_page = tag;

  // register accesses always answer in one clock
  assign reg_ack = reg_valid;
  assign reg_err = reg_valid && ((reg_target == `FBI_REG_UNIMP) ||
                   (q.stop_r && (reg_target != `FBI_REG_MCR))); // [R12] [R11]
  assign mcr_wr = reg_valid && reg_write && (reg_target == `FBI_REG_MCR);
  assign hvc_wr = reg_valid && reg_write && (reg_target == `FBI_REG_HVC) && !reg_err;

  // leaving stop or disabled drops both pages so the first read is fresh
  assign inval = mcr_wr && !q.seq_r &&
                 ((q.stop_r && !reg_wdata_stop) || (q.dis_r && !reg_wdata_dis)); // [R22]

  // next state
  always_comb begin
    d = q;
    d.start_r = 1'b0;
    d.pgm_wr_r = 1'b0;
    // recovery countdown after stop exit
    if (recovering) begin
      d.rec_cnt_r = q.rec_cnt_r - 5'h01; // [R14]
    end
    // stop and disable only change while no high-voltage sequence runs
    if (mcr_wr && !q.seq_r) begin // [R10] [R16] [R21]
      d.stop_r = reg_wdata_stop; // [R09]
      d.dis_r = reg_wdata_dis; // [R15] [R17]
      if (q.stop_r && !reg_wdata_stop) begin
        d.rec_cnt_r = `FBI_RECOVERY_CLKS; // [R14]
      end
    end
    // sequence bit and start of program or erase
    if (hvc_wr) begin
      d.seq_r = reg_wdata_seq;
      if (!q.seq_r && reg_wdata_seq) begin
        d.start_r = 1'b1; // [R18]
      end
      if (!reg_wdata_seq) begin
        d.pgm_sel_r = 8'h00;
        d.pgm_off_vld_r = 1'b0;
      end
    end
    // accepted programming write loads the block's program page
    if (arr_live && req_write && !attr_err && wr_ok) begin
      d.pgm_sel_r = q.pgm_sel_r | (8'h01 << blk); // [R06]
      d.pgm_off_r = off;
      d.pgm_off_vld_r = 1'b1;
      d.pgm_wr_r = 1'b1;
      d.pgm_addr_r = req_addr;
      d.pgm_data_r = req_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // lower-block read page
  fbi_page_buf #(.TAG_W(12), .WORDS(`FBI_PAGE_WORDS)) u_page_lo (
    .clk(clk),
    .rst_n(rst_n),
    .fill(arr_rd_en && !blk[2]), // [R04]
    .inval(inval),
    .fill_tag(tag),
    .fill_data(arr_rd_data),
    .look_tag(tag),
    .look_word(wsel),
    .hit(hit_lo),
    .word(word_lo)
  );

  // upper-block read page
  fbi_page_buf #(.TAG_W(12), .WORDS(`FBI_PAGE_WORDS)) u_page_hi (
    .clk(clk),
    .rst_n(rst_n),
    .fill(arr_rd_en && blk[2]), // [R04]
    .inval(inval),
    .fill_tag(tag),
    .fill_data(arr_rd_data),
    .look_tag(tag),
    .look_word(wsel),
    .hit(hit_hi),
    .word(word_hi)
  );

  // registered outputs
  assign pgm_wr = q.pgm_wr_r;
  assign pgm_addr = q.pgm_addr_r;
  assign pgm_data = q.pgm_data_r;
  assign pgm_blk_sel = q.pgm_sel_r;
  assign flash_stop_bit = q.stop_r;
  assign array_disable_bit = q.dis_r;
  assign program_erase_sequence_bit = q.seq_r;
  assign pe_start = q.start_r;
  assign low_power = q.stop_r; // [R09]

endmodule

`default_nettype wire

// [rtl/fbi_page_buf.sv]
`timescale 1ns/100ps
`default_nettype none

module fbi_page_buf #(
  parameter int TAG_W = 12,
  parameter int WORDS = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill and invalidate
  input wire logic fill,
  input wire logic inval,
  input wire logic [TAG_W-1:0] fill_tag,
  input wire logic [WORDS*32-1:0] fill_data,
  // lookup
  input wire logic [TAG_W-1:0] look_tag,
  input wire logic [2:0] look_word,
  output logic hit,
  output logic [31:0] word
);
  import fbi_pkg::*;

  fbi_page_t q, d;

  // invalidate wins over a fill in the same cycle
  always_comb begin
    d = q;
    if (inval) begin
      d.valid_r = 1'b0;
    end else if (fill) begin
      d.valid_r = 1'b1;
      d.tag_r = fill_tag;
      d.data_r = fill_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // compare the access address against the retained page
  assign hit = q.valid_r && (q.tag_r == look_tag);
  assign word = q.data_r[look_word*32 +: 32];

endmodule

`default_nettype wire

// [rtl/fbi_pkg.sv]
package fbi_pkg;

  // block state of the bus interface unit
  typedef struct packed {
    logic stop_r;
    logic dis_r;
    logic seq_r;
    logic start_r;
    logic [4:0] rec_cnt_r;
    logic [7:0] pgm_sel_r;
    logic [7:0] pgm_off_r;
    logic pgm_off_vld_r;
    logic pgm_wr_r;
    logic [16:0] pgm_addr_r;
    logic [31:0] pgm_data_r;
  } fbi_state_t;

  // one retained read page
  typedef struct packed {
    logic valid_r;
    logic [11:0] tag_r;
    logic [255:0] data_r;
  } fbi_page_t;

endpackage

// [rtl/fbi_regs.svh]
`ifndef FBI_REGS_SVH
`define FBI_REGS_SVH

// array geometry
`define FBI_NUM_BLOCKS 8
`define FBI_BLOCK_BYTES 16384
`define FBI_ARRAY_BYTES 131072
`define FBI_ADDR_W 17
`define FBI_BLK_LSB 14
`define FBI_BLK_MSB 16

// read page: 32 bytes, eight 32-bit words
`define FBI_PAGE_BYTES 32
`define FBI_PAGE_WORDS 8
`define FBI_PAGE_LSB 5
`define FBI_WORD_LSB 2
`define FBI_WORD_MSB 4

// program page: 64 bytes, offset within the block
`define FBI_PGM_PAGE_BYTES 64
`define FBI_PGM_OFF_LSB 6
`define FBI_PGM_OFF_MSB 13

// control register targets
`define FBI_REG_MCR 2'h0
`define FBI_REG_TEST 2'h1
`define FBI_REG_HVC 2'h2
`define FBI_REG_UNIMP 2'h3

// recovery after leaving stop mode, in clocks
`define FBI_RECOVERY_CLKS 5'h10

`endif

// [verif/fbi_array_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fbi_array_model (
  // page fetch port
  input wire logic arr_rd_en,
  input wire logic [11:0] arr_rd_page,
  output logic [255:0] arr_rd_data
);
  // word n of page p holds {p, n}; inverted when idle so stale data never matches
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      arr_rd_data[32*i+:32] = {4'h0, arr_rd_page, 13'h0, i[2:0]} ^ {32{!arr_rd_en}};
    end
  end
endmodule
`default_nettype wire

// [verif/fbi_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module fbi_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // array and register bus
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ack,
  input wire logic req_err,
  input wire logic arr_rd_en,
  input wire logic reg_valid,
  input wire logic reg_write,
  input wire logic [1:0] reg_target,
  input wire logic reg_wdata_seq,
  input wire logic reg_err,
  // control state
  input wire logic flash_stop_bit,
  input wire logic array_disable_bit,
  input wire logic program_erase_sequence_bit,
  input wire logic pe_start
);
  // one domain, so one clocking and one reset gate
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_miss;
    req_valid && !req_write && arr_rd_en |-> !req_ack ##1 req_ack;
  endproperty
  a_miss: assert property (p_miss) else $error("miss timing");
  property p_stop;
    flash_stop_bit |-> !req_ack && !arr_rd_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ack");
  property p_dis;
    array_disable_bit |-> !req_ack && !arr_rd_en;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled ack");
  property p_serr;
    reg_valid && flash_stop_bit && reg_target != 2'h0 |-> reg_err;
  endproperty
  a_serr: assert property (p_serr) else $error("no stop error");
  property p_werr;
    req_write && req_ack && !program_erase_sequence_bit |-> req_err;
  endproperty
  a_werr: assert property (p_werr) else $error("write not refused");
  // recovery: sixteen clocks of silence once stop drops
  property p_rec;
    $fell(flash_stop_bit) |-> !req_ack [*8] ##1 !req_ack [*8];
  endproperty
  a_rec: assert property (p_rec) else $error("early ack");
  property p_keep;
    reg_valid && reg_write && reg_target == 2'h0 && program_erase_sequence_bit
      |=> $stable(flash_stop_bit) && $stable(array_disable_bit);
  endproperty
  a_keep: assert property (p_keep) else $error("mode bit moved");
  property p_start;
    reg_valid && reg_write && reg_target == 2'h2 && reg_wdata_seq
      && !program_erase_sequence_bit |=> pe_start;
  endproperty
  a_start: assert property (p_start) else $error("no start");
endmodule
bind fbi_flash_bus_interface_unit fbi_chk i_fbi_chk (.clk(clk), .rst_n(rst_n),
  .req_valid(req_valid), .req_write(req_write), .req_ack(req_ack), .req_err(req_err),
  .arr_rd_en(arr_rd_en), .reg_valid(reg_valid), .reg_write(reg_write),
  .reg_target(reg_target), .reg_wdata_seq(reg_wdata_seq), .reg_err(reg_err),
  .flash_stop_bit(flash_stop_bit), .array_disable_bit(array_disable_bit),
  .program_erase_sequence_bit(program_erase_sequence_bit), .pe_start(pe_start));
`default_nettype wire

// [verif/test_flash_array_bus_interface.sv]
`timescale 1ns/100ps
`default_nettype none
module test_flash_array_bus_interface;
  logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_super = 1, req_data = 1;
  logic reg_valid = 0, reg_write = 0, reg_wdata_stop = 0, reg_wdata_dis = 0, reg_wdata_seq = 0;
  logic [16:0] req_addr = 17'h0, pgm_addr;
  logic [31:0] req_wdata = 32'h0, req_rdata, pgm_data;
  logic [1:0] reg_target = 2'h0;
  logic [7:0] blk_protect = 8'h80, blk_super_only = 8'h04, blk_data_only = 8'h08, pgm_blk_sel;
  logic req_ack, req_err, reg_ack, reg_err, arr_rd_en, pgm_wr, pe_start, low_power;
  logic flash_stop_bit, array_disable_bit, program_erase_sequence_bit;
  logic [11:0] arr_rd_page;
  logic [255:0] arr_rd_data;
  int n_mismatch = 0, n_compared = 0, lat_seen;
  always #50 clk = ~clk;
  fbi_flash_bus_interface_unit i_fbi_flash_bus_interface_unit (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_super(req_super), .req_data(req_data), .req_ack(req_ack), .req_err(req_err),
    .req_rdata(req_rdata), .reg_valid(reg_valid), .reg_write(reg_write),
    .reg_target(reg_target), .reg_wdata_stop(reg_wdata_stop), .reg_wdata_dis(reg_wdata_dis),
    .reg_wdata_seq(reg_wdata_seq), .reg_ack(reg_ack), .reg_err(reg_err),
    .blk_protect(blk_protect), .blk_super_only(blk_super_only), .blk_data_only(blk_data_only),
    .arr_rd_en(arr_rd_en), .arr_rd_page(arr_rd_page), .arr_rd_data(arr_rd_data),
    .pgm_wr(pgm_wr), .pgm_addr(pgm_addr), .pgm_data(pgm_data), .pgm_blk_sel(pgm_blk_sel),
    .flash_stop_bit(flash_stop_bit), .array_disable_bit(array_disable_bit),
    .program_erase_sequence_bit(program_erase_sequence_bit), .pe_start(pe_start),
    .low_power(low_power));
  fbi_array_model i_fbi_array_model (.arr_rd_en(arr_rd_en), .arr_rd_page(arr_rd_page),
    .arr_rd_data(arr_rd_data));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // array access; lat is the expected cycle of ack, lim+1 means never, -1 means unchecked
  task acc(input logic w, input logic [16:0] a, input int lat, input int lim, input logic e);
    int n;
    @(negedge clk);
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = {15'h0, a};
    for (n = 1; n <= lim; n++) begin
      #40;
      if (req_ack === 1'b1) break;
      @(negedge clk);
    end
    lat_seen = n;
    if (lat >= 0) chk(n, lat);
    // a wait that runs out where an answer was due is a mismatch, even when unchecked
    if (n > lim && lat != lim + 1) begin
      n_mismatch++;
      $display("MISMATCH %0t no answer within %0d cycles", $time, lim);
      end_sim;
    end
    if (n <= lim) begin
      chk(req_err, e);
      if (!w && !e) chk(req_rdata, {4'h0, a[16:5], 13'h0, a[4:2]});
      @(negedge clk);
    end
    req_valid = 0;
  endtask
  // control register access, one cycle, answered in that cycle
  task rg(input logic [1:0] t, input logic w, s, d, q, e);
    @(negedge clk);
    reg_valid = 1;
    reg_write = w;
    reg_target = t;
    reg_wdata_stop = s;
    reg_wdata_dis = d;
    reg_wdata_seq = q;
    #40;
    chk(reg_ack, 1);
    chk(reg_err, e);
    @(negedge clk);
    reg_valid = 0;
  endtask
  task s_read;
    acc(0, 17'h00000, 2, 4, 0);
    acc(0, 17'h0001C, 1, 4, 0);
    acc(0, 17'h10000, 2, 4, 0);
    acc(0, 17'h00004, 1, 4, 0);
    acc(0, 17'h00020, 2, 4, 0);
    acc(0, 17'h10008, 1, 4, 0);
    acc(0, 17'h1FFFC, 2, 4, 0);
    acc(1, 17'h00000, 1, 4, 1);
    rg(2'h3, 0, 0, 0, 0, 1);
  endtask
  task s_attr;
    req_super = 0;
    acc(0, 17'h08000, 1, 4, 1);
    req_super = 1;
    req_data = 0;
    acc(0, 17'h0C000, 1, 4, 1);
    req_data = 1;
  endtask
  task s_prog;
    rg(2'h2, 1, 0, 0, 1, 0);
    chk(pe_start, 1);
    acc(1, 17'h00040, 1, 4, 0);
    chk(pgm_wr, 1);
    chk(pgm_addr, 32'h00000040);
    chk(pgm_data, 32'h00000040);
    acc(1, 17'h04040, 1, 4, 0);
    chk(pgm_blk_sel, 8'h03);
    acc(1, 17'h1C040, 1, 4, 1);
    acc(1, 17'h08080, 1, 4, 1);
    rg(2'h0, 1, 1, 0, 0, 0);
    chk(flash_stop_bit, 0);
    rg(2'h0, 1, 0, 1, 0, 0);
    chk(array_disable_bit, 0);
    rg(2'h2, 1, 0, 0, 0, 0);
    chk(pgm_blk_sel, 8'h00);
  endtask
  // stop written alone each time, never with other bits
  task s_stop;
    rg(2'h0, 1, 1, 0, 0, 0);
    chk(low_power, 1);
    acc(0, 17'h00000, 9, 8, 0);
    rg(2'h1, 0, 0, 0, 0, 1);
    rg(2'h0, 0, 0, 0, 0, 0);
    rg(2'h0, 1, 0, 0, 0, 0);
    acc(0, 17'h00000, -1, 30, 0);
    chk(lat_seen >= 16 && lat_seen <= 17, 1);
  endtask
  task s_dis;
    rg(2'h0, 1, 0, 1, 0, 0);
    acc(0, 17'h00000, 9, 8, 0);
    rg(2'h0, 1, 0, 0, 0, 0);
    acc(0, 17'h00000, 2, 4, 0);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    s_read;
    s_attr;
    s_prog;
    s_stop;
    s_dis;
    end_sim;
  end
endmodule
`default_nettype wire
